// file: verif/rx_zero_suppress_decoder_los_test.sv
// Self-checking bench for the receive decoder with loss detection.
`timescale 1ns/1ps

module rx_zero_suppress_decoder_los_test;
	import rzd_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	rzd_pins_t pins = '0;
	rzd_rate_t rate = RATE_DS3;
	logic [4:0] ctl = 5'h00;
	logic rp, rn, code_err, stb, los, got;
	logic [2:0] sym;
	rzd_status_t st;
	rzd_lvl_t lvl;
	logic [3:0] q[$];
	int error_cnt = 0;
	int tests_run = 0;
	wire [7:0] lv = {4'h0, los, st.signal_loss_indication, st.amplitude_loss, st.zero_run_loss};

	always #2 clk = ~clk;

	rzd_decoder #(.LOS_DELAY_UI(8'h0A)) dut (.i_clk(clk), .i_resetn(rstn), .i_pins(pins),
		.i_rate_mode(rate), .i_receive_control_two(ctl), .o_rpos(rp), .o_rneg(rn),
		.o_line_code_violation_out(code_err), .o_data_strobe(stb),
		.o_signal_loss_indication(los),
		.o_receive_alarm_status(st), .o_amp_level_sel(lvl));
	rzd_framer_model fm (.i_clk(clk), .i_stb(stb), .i_sym({rp, rn, code_err}), .o_got(got),
		.o_sym(sym));

	task automatic check(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test;
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [3:0] enc(input byte c);
		case (c)
			"p": return 4'hC;
			"n": return 4'hA;
			"0": return 4'h8;
			"z": return 4'h9;
			"P": return 4'hD;
			"N": return 4'hB;
			default: return 4'h0;
		endcase
	endfunction

	task automatic sym1(input byte c);
		pins.pos = (c == "p");
		pins.neg = (c == "n");
		repeat (8) @(negedge clk);
		pins.rclk = 1'b1;
		repeat (8) @(negedge clk);
		pins.rclk = 1'b0;
	endtask

	task automatic many(input byte c, input int n);
		repeat (n)
		begin
			sym1(c);
			if (c != "0")
				c = (c == "p") ? "n" : "p";
		end
		repeat (8) @(negedge clk);
	endtask

	task automatic run(input string si, input string se);
		repeat (4) q.push_back(4'h0);
		foreach (se[i]) q.push_back(enc(se[i]));
		foreach (si[i]) sym1(si[i]);
		repeat (8) @(negedge clk);
		check(8'(q.size()), 8'h00);
	endtask

	task automatic rst(input logic h, input logic [4:0] c, input logic pd, input rzd_rate_t r);
		rstn = 1'b0;
		pins.host_mode = h;
		pins.codec_disable = pd;
		ctl = c;
		rate = r;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	task automatic amp(input logic lo, input logic ok);
		pins.amp_low = lo;
		pins.amp_ok = ok;
		repeat (8) @(negedge clk);
	endtask

	always @(posedge clk)
		if (got === 1'b1 && q.size() > 0)
		begin
			if (q[0][3])
				check({5'h00, sym}, {5'h00, q[0][2:0]});
			void'(q.pop_front());
		end

	initial
	begin
		#200000;
		error_cnt++;
		end_of_test;
	end

	initial
	begin
		void'($urandom(4));
		rst(1'b1, 5'h00, 1'b1, RATE_STS1);
		run("pnpn00np0pnpp000npnpn", "??pn000000npP00zn");
		rst(1'b0, 5'h08, 1'b0, RATE_DS3);
		run("pnpn00np0pnpp000npnpn", "??pn000000npP00zn");
		rst(1'b1, 5'h00, 1'b0, RATE_E3);
		run("pn000np00pn0n0000pnpnp", "??00000000n0N000zp");
		rst(1'b0, 5'h00, 1'b1, RATE_DS3);
		run("pnn00npp000pnpnp", "??n00npp00zp");
		rst(1'b1, 5'h08, 1'b0, RATE_STS1);
		run("pnn00npp000pnpnp", "??n00npp00zp");
		rst(1'b1, 5'h00, 1'b0, RATE_DS3);
		amp(1'b1, 1'b0);
		check(lv, 8'h0E);
		amp(1'b0, 1'b1);
		check(lv, 8'h00);
		ctl = 5'h04;
		amp(1'b1, 1'b0);
		check(lv, 8'h00);
		ctl = 5'h00;
		amp(1'b0, 1'b1);
		many("0", 159);
		check(lv, 8'h00);
		many("0", 1);
		check(lv, 8'h0D);
		many("p", 120);
		check(lv, 8'h0D);
		many("p", 16);
		check(lv, 8'h00);
		ctl = 5'h06;
		amp(1'b1, 1'b0);
		many("0", 170);
		check(lv, 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			{pins.host_mode, pins.equalizer_on, pins.threshold_select, pins.lock_lost,
				pins.driver_monitor_alarm, ctl[0]} = 6'($urandom);
			rate = ($urandom % 2) ? RATE_STS1 : RATE_DS3;
			repeat (8) @(negedge clk);
			check({3'h0, st.lock_lost, st.driver_monitor_alarm, lvl}, {3'h0, pins.lock_lost,
				pins.driver_monitor_alarm, rate == RATE_STS1,
				pins.host_mode ? ctl[0] : pins.equalizer_on, pins.threshold_select});
		end
		rst(1'b1, 5'h00, 1'b0, RATE_E3);
		amp(1'b1, 1'b0);
		many("p", 7);
		check(lv, 8'h02);
		many("p", 6);
		check(lv, 8'h0E);
		amp(1'b0, 1'b1);
		many("p", 7);
		check(lv, 8'h0C);
		many("p", 6);
		check(lv, 8'h00);
		end_of_test;
	end
endmodule // rx_zero_suppress_decoder_los_test

// file: verif/rzd_framer_model.sv
// Framer model that captures each decoded symbol on its data strobe.
`timescale 1ns/1ps

module rzd_framer_model (
	// Clock and strobe.
	input wire logic i_clk,
	input wire logic i_stb,
	// Decoded symbol as rpos, rneg, violation.
	input wire logic [2:0] i_sym,
	// Captured symbol.
	output logic o_got,
	output logic [2:0] o_sym
);
	always_ff @(posedge i_clk)
	begin
		o_got <= i_stb;
		if (i_stb)
			o_sym <= i_sym;
	end
endmodule // rzd_framer_model

// file: verilog/rzd_decoder.sv
// Receive zero-suppression decoder with loss-of-signal detection for one channel.
`timescale 1ns/1ps

module rzd_decoder #(
	parameter logic [7:0] LOS_DELAY_UI = rzd_pkg::LOS_E3_UI
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_resetn,
	// Line side pins.
	input wire rzd_pkg::rzd_pins_t i_pins,
	// Configuration from host logic.
	input wire rzd_pkg::rzd_rate_t i_rate_mode,
	input wire logic [rzd_pkg::REG_W-1:0] i_receive_control_two,
	// Decoded data to the framer.
	output logic o_rpos,
	output logic o_rneg,
	output logic o_line_code_violation_out,
	output logic o_data_strobe,
	// Alarms and amplitude level selection.
	output logic o_signal_loss_indication,
	output rzd_pkg::rzd_status_t o_receive_alarm_status,
	output rzd_pkg::rzd_lvl_t o_amp_level_sel
);
	import rzd_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		rzd_pins_t meta;
		rzd_pins_t sync;
		logic rclk_q;
		rzd_sym_t [3:0] dly;
		logic last_neg;
		logic [7:0] zrun;
		logic zl;
		logic [4:0] win_pos;
		logic [5:0] ones;
		logic [2:0] good;
		logic al;
		logic los;
		logic [7:0] los_cnt;
		logic pos_q;
		logic neg_q;
		logic code_err_q;
		logic stb;
		rzd_lvl_t lvl;
	} rzd_state_t;

	rzd_state_t s_reg;
	rzd_state_t s_next;
	logic edge_det;
	logic is_e3;
	logic codec_on;
	logic aoff;
	logic zoff;
	logic raw_loss;
	logic raw_zero;
	logic viol;
	rzd_sym_t cur;
	logic [7:0] znext;
	logic [7:0] zlim;
	logic [5:0] ones_n;
	logic [2:0] good_n;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.meta = i_pins;
		s_next.sync = s_reg.meta;
		s_next.rclk_q = s_reg.sync.rclk;
		s_next.stb = 1'b0;
		edge_det = s_reg.sync.rclk & ~s_reg.rclk_q;
		is_e3 = (i_rate_mode == RATE_E3);
		if (s_reg.sync.host_mode)
		begin
			codec_on = ~i_receive_control_two[CTRL_CDIS_BIT];
			aoff = i_receive_control_two[CTRL_AOFF_BIT];
			zoff = i_receive_control_two[CTRL_ZOFF_BIT];
			s_next.lvl.equalizer_on = i_receive_control_two[CTRL_EQ_BIT];
		end
		else
		begin
			codec_on = ~s_reg.sync.codec_disable;
			aoff = 1'b0;
			zoff = 1'b0;
			s_next.lvl.equalizer_on = s_reg.sync.equalizer_on;
		end
		s_next.lvl.threshold_select = s_reg.sync.threshold_select;
		s_next.lvl.sts1 = (i_rate_mode == RATE_STS1);
		zlim = is_e3 ? ZLIM_FOUR : ZLIM_THREE;
		cur.pulse = s_reg.sync.pos | s_reg.sync.neg;
		cur.neg = s_reg.sync.neg & ~s_reg.sync.pos;
		cur.code_err = 1'b0;
		raw_zero = ~cur.pulse;
		viol = cur.pulse & (cur.neg == s_reg.last_neg);
		znext = raw_zero ? ((s_reg.zrun == ZR_MAX) ? ZR_MAX : s_reg.zrun + 8'h01) : 8'h00;
		ones_n = s_reg.ones + {5'h00, cur.pulse};
		good_n = s_reg.good;
		// Amplitude detector with hysteresis from the two comparators.
		if (aoff)
			s_next.al = 1'b0;
		else if (s_reg.sync.amp_low)
			s_next.al = 1'b1;
		else if (s_reg.sync.amp_ok)
			s_next.al = 1'b0;
		if (edge_det)
		begin
			s_next.stb = 1'b1;
			s_next.pos_q = s_reg.dly[3].pulse & ~s_reg.dly[3].neg;
			s_next.neg_q = s_reg.dly[3].pulse & s_reg.dly[3].neg;
			s_next.code_err_q = s_reg.dly[3].code_err;
			s_next.zrun = znext;
			if (raw_zero && znext == zlim)
				cur.code_err = 1'b1;
			if (cur.pulse)
				s_next.last_neg = cur.neg;
			if (codec_on && viol)
			begin
				if (is_e3 && !s_reg.dly[0].pulse && !s_reg.dly[1].pulse)
				begin
					cur.pulse = 1'b0;
					s_next.dly[1].pulse = 1'b0;
					s_next.dly[2].pulse = 1'b0;
					s_next.dly[3].pulse = 1'b0;
				end
				else if (!is_e3 && !s_reg.dly[0].pulse)
				begin
					cur.pulse = 1'b0;
					s_next.dly[1].pulse = 1'b0;
					s_next.dly[2].pulse = 1'b0;
				end
				else
					cur.code_err = 1'b1;
			end
			s_next.dly[0] = cur;
			if (!(codec_on && viol && (is_e3 ? (!s_reg.dly[0].pulse && !s_reg.dly[1].pulse)
				: !s_reg.dly[0].pulse)))
			begin
				s_next.dly[1] = s_reg.dly[0];
				s_next.dly[2] = s_reg.dly[1];
				s_next.dly[3] = s_reg.dly[2];
			end
			else
			begin
				s_next.dly[1] = '{pulse: 1'b0, neg: s_reg.dly[0].neg,
					code_err: s_reg.dly[0].code_err};
				s_next.dly[2] = '{pulse: 1'b0, neg: s_reg.dly[1].neg,
					code_err: s_reg.dly[1].code_err};
				s_next.dly[3] = '{pulse: is_e3 ? 1'b0 : s_reg.dly[2].pulse,
					neg: s_reg.dly[2].neg, code_err: s_reg.dly[2].code_err};
			end
			// Zero-run detector and its window-based clearance.
			if (!s_reg.zl)
			begin
				if (znext >= ZR_DECLARE)
				begin
					s_next.zl = 1'b1;
					s_next.win_pos = 5'h00;
					s_next.ones = 6'h00;
					s_next.good = 3'h0;
				end
			end
			else if (s_reg.win_pos == WIN_LAST)
			begin
				good_n = (ones_n >= WIN_ONES) ? s_reg.good + 3'h1 : 3'h0;
				s_next.good = good_n;
				s_next.win_pos = 5'h00;
				s_next.ones = 6'h00;
				if (good_n == WIN_GOOD)
					s_next.zl = 1'b0;
			end
			else
			begin
				s_next.win_pos = s_reg.win_pos + 5'h01;
				s_next.ones = ones_n;
			end
		end
		if (zoff)
			s_next.zl = 1'b0;
		raw_loss = s_reg.al | s_reg.zl;
		if (!is_e3)
		begin
			s_next.los = raw_loss;
			s_next.los_cnt = 8'h00;
		end
		else if (edge_det)
		begin
			if (raw_loss == s_reg.los)
				s_next.los_cnt = 8'h00;
			else if (s_reg.los_cnt >= LOS_DELAY_UI - 8'h01)
			begin
				s_next.los = raw_loss;
				s_next.los_cnt = 8'h00;
			end
			else
				s_next.los_cnt = s_reg.los_cnt + 8'h01;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rpos = s_reg.pos_q;
	assign o_rneg = s_reg.neg_q;
	assign o_line_code_violation_out = s_reg.code_err_q;
	assign o_data_strobe = s_reg.stb;
	assign o_signal_loss_indication = s_reg.los;
	assign o_amp_level_sel = s_reg.lvl;
	assign o_receive_alarm_status.lock_lost = s_reg.sync.lock_lost;
	assign o_receive_alarm_status.signal_loss_indication = s_reg.los;
	assign o_receive_alarm_status.amplitude_loss = s_reg.al;
	assign o_receive_alarm_status.zero_run_loss = s_reg.zl;
	assign o_receive_alarm_status.driver_monitor_alarm = s_reg.sync.driver_monitor_alarm;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence seq_sub_three;
		edge_det && codec_on && !is_e3 && viol && !s_reg.dly[0].pulse;
	endsequence

	sequence seq_sub_four;
		edge_det && codec_on && is_e3 && viol && !s_reg.dly[0].pulse && !s_reg.dly[1].pulse;
	endsequence

	sub_three_a: assert property (seq_sub_three |=>
		!s_reg.dly[0].pulse && !s_reg.dly[1].pulse && !s_reg.dly[2].pulse)
		else $error("three-zero substitution left a pulse");
	sub_four_a: assert property (seq_sub_four |=> !s_reg.dly[0].pulse && !s_reg.dly[1].pulse
		&& !s_reg.dly[2].pulse && !s_reg.dly[3].pulse)
		else $error("four-zero substitution left a pulse");
	stray_viol_a: assert property (edge_det && codec_on && viol && s_reg.dly[0].pulse
		|=> s_reg.dly[0].code_err)
		else $error("stray violation not flagged");
	zero_run_a: assert property (edge_det && raw_zero && znext == zlim
		|=> s_reg.dly[0].code_err)
		else $error("excess zero run not flagged");
	viol_align_a: assert property (edge_det |=> o_line_code_violation_out
		== $past(s_reg.dly[3].code_err))
		else $error("violation flag not aligned with its symbol");
	lcv_hold_a: assert property (!edge_det |=> $stable(o_line_code_violation_out))
		else $error("violation output moved between symbols");
	los_or_a: assert property (!is_e3 |=> o_signal_loss_indication == $past(raw_loss))
		else $error("loss output is not the detector OR");
	amp_off_a: assert property (aoff |=> !o_receive_alarm_status.amplitude_loss)
		else $error("amplitude loss while detector off");
	amp_set_a: assert property (!aoff && s_reg.sync.amp_low
		|=> o_receive_alarm_status.amplitude_loss)
		else $error("amplitude loss not declared");
	zr_declare_a: assert property (edge_det && !zoff && !s_reg.zl && znext >= ZR_DECLARE
		|=> s_reg.zl)
		else $error("zero-run loss not declared");
	both_off_a: assert property (aoff && zoff ##1 aoff && zoff |=> !raw_loss)
		else $error("loss source active with both detectors off");
	e3_hold_a: assert property (is_e3 && $changed(o_signal_loss_indication) && $past(is_e3)
		|-> $past(s_reg.los_cnt) >= LOS_DELAY_UI - 8'h01)
		else $error("four-zero loss changed without its delay");

endmodule // rzd_decoder

// file: verilog/rzd_pkg.sv
// Package of constants and types for the receive decoder.
package rzd_pkg;

	// ----------------------------------------
	// Register fields
	// ----------------------------------------
	localparam int CTRL_EQ_BIT = 0;
	localparam int CTRL_ZOFF_BIT = 1;
	localparam int CTRL_AOFF_BIT = 2;
	localparam int CTRL_CDIS_BIT = 3;
	localparam int REG_W = 5;

	// ----------------------------------------
	// Counts
	// ----------------------------------------
	localparam logic [7:0] ZR_DECLARE = 8'hA0;
	localparam logic [7:0] ZR_MAX = 8'hFF;
	localparam logic [4:0] WIN_LAST = 5'h1F;
	localparam logic [5:0] WIN_ONES = 6'h0A;
	localparam logic [2:0] WIN_GOOD = 3'h4;
	localparam logic [7:0] ZLIM_THREE = 8'h03;
	localparam logic [7:0] ZLIM_FOUR = 8'h04;
	localparam logic [7:0] LOS_E3_UI = 8'h20;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		RATE_DS3 = 2'b00,
		RATE_STS1 = 2'b01,
		RATE_E3 = 2'b10
	} rzd_rate_t;

	typedef struct packed {
		logic rclk;
		logic pos;
		logic neg;
		logic lock_lost;
		logic driver_monitor_alarm;
		logic amp_low;
		logic amp_ok;
		logic codec_disable;
		logic equalizer_on;
		logic threshold_select;
		logic host_mode;
	} rzd_pins_t;

	typedef struct packed {
		logic pulse;
		logic neg;
		logic code_err;
	} rzd_sym_t;

	typedef struct packed {
		logic sts1;
		logic equalizer_on;
		logic threshold_select;
	} rzd_lvl_t;

	typedef struct packed {
		logic lock_lost;
		logic signal_loss_indication;
		logic amplitude_loss;
		logic zero_run_loss;
		logic driver_monitor_alarm;
	} rzd_status_t;

endpackage
